// File: core/ckc_regs.svh
`ifndef CKC_REGS_SVH
`define CKC_REGS_SVH
// register byte offsets
`define CKC_OFS_CLKDIV   12'h000
`define CKC_OFS_FBD      12'h004
`define CKC_OFS_TRIM     12'h008
`define CKC_OFS_AUX      12'h00C
`define CKC_OFS_REFO     12'h010
`define CKC_OFS_PRN      12'h014
`define CKC_OFS_OSC      12'h018
`define CKC_OFS_PSAV     12'h01C
// speed control fields
`define CKC_B_RESTORE    15
`define CKC_F_RATIO_HI   14
`define CKC_F_RATIO_LO   12
`define CKC_B_SLOW_EN    11
`define CKC_F_PRE_HI     4
`define CKC_F_PRE_LO     0
`define CKC_RST_RATIO    3'h3
`define CKC_RATIO_ZERO   3'h0
`define CKC_PRE_OFFSET   6'h02
`define CKC_FB_OFFSET    10'h002
// feedback, trim, pseudorandom
`define CKC_F_FB_HI      8
`define CKC_RST_FB       9'h030
`define CKC_F_TRIM_HI    5
`define CKC_F_PRN_HI     14
// aux clock control
`define CKC_B_AUX_ON     15
`define CKC_B_AUX_LOCK   14
`define CKC_B_AUX_RCSEL  6
`define CKC_B_AUX_SRC    7
`define CKC_RST_AUX_RC   1'h1
`define CKC_AUX_MULT     16
// reference output
`define CKC_B_REF_ON     15
`define CKC_F_REFDIV_HI  11
`define CKC_F_REFDIV_LO  8
// oscillator control
`define CKC_F_NEW_OSCILLATOR_SELECT_HI    10
`define CKC_F_NEW_OSCILLATOR_SELECT_LO    8
`define CKC_B_CLK_LOCK   7
// power save command
`define CKC_B_PSAV_MODE  0
`endif

// File: core/ckc_pkg.sv
package ckc_pkg;
   typedef enum logic {CKC_SLEEP, CKC_IDLE} ckc_psave_mode_t;
   typedef enum logic [1:0] {CKC_RUN, CKC_IN_SLEEP, CKC_IN_IDLE} ckc_power_t;
endpackage : ckc_pkg

// File: core/ckc_clock_ctrl.sv
//Contract
// RULE1: setting slowdown enable is ignored while slowdown ratio code is zero.
// RULE2: ratio writes are discarded while slowdown enable is set.
// RULE3: with restore bit set, an interrupt clears slowdown enable.
// RULE4: pll input divider divides by code plus two, reset code zero.
// RULE5: feedback value in bits 8:0, bits 15:9 read zero.
// RULE6: six-bit rc trim field, reset zero selects center frequency.
// RULE7: aux pll input follows source select unless rc select bit is one.
// RULE8: software clears ref output enable before writing ref divider.
// RULE9: 15-bit pseudorandom register, bit 15 reads zero, reset zero.
// RULE10: new oscillator select writable only while clock config unlocked.
// RULE11: power save command enters sleep or idle per its mode operand.
// RULE12: ratio selects one of eight cpu ratios, 1:1 to 1:128.
// RULE13: aux pll multiplies its selected input by sixteen.
// RULE14: aux pll locked bit is read-only and mirrors lock state.
// RULE15: ref divider passes clock at zero, else divides by two to n.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "ckc_regs.svh"
module ckc_clock_ctrl (
   // clock, reset, enable
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  clk_en,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // system events
   input  wire logic                  irq_event,
   input  wire logic                  aux_pll_lock_pin,
   input  wire logic                  wake_event,
   // clock settings out
   output logic      [7:0]            cpu_ratio_div,
   output logic      [5:0]            pll_in_div,
   output logic      [9:0]            pll_fb_mult,
   output logic      [5:0]            rc_trim_value,
   output logic                       aux_pll_on,
   output logic                       aux_use_internal_rc,
   output logic      [4:0]            aux_pll_mult,
   output logic                       ref_clock_output_on,
   output logic      [15:0]           ref_div_ratio_log2,
   output logic      [2:0]            new_oscillator_select,
   output ckc_pkg::ckc_power_t        power_state
);
   import ckc_pkg::*;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic        interrupt_restore_speed;
   logic [2:0]  slow_ratio;
   logic        cpu_slow_enable;
   logic [4:0]  pll_input_divider;
   logic [8:0]  pll_feedback_value;
   logic        aux_pll_internal_rc_select;
   logic        aux_source_select;
   logic [3:0]  ref_clock_divider;
   logic [14:0] pseudorandom_value;
   logic        clock_locked;
   logic        lock_s1;
   logic        lock_s2;
   logic        irq_s1;
   logic        irq_s2;
   logic        wake_s1;
   logic        wake_s2;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire         wr_go   = clk_en & psel & penable & pwrite;
   wire         rd_go   = clk_en & psel & ~penable & ~pwrite;
   wire         hit_div = paddr == `CKC_OFS_CLKDIV;
   wire         hit_fbd = paddr == `CKC_OFS_FBD;
   wire         hit_trm = paddr == `CKC_OFS_TRIM;
   wire         hit_aux = paddr == `CKC_OFS_AUX;
   wire         hit_ref = paddr == `CKC_OFS_REFO;
   wire         hit_prn = paddr == `CKC_OFS_PRN;
   wire         hit_osc = paddr == `CKC_OFS_OSC;
   wire         hit_psv = paddr == `CKC_OFS_PSAV;
   wire         mapped  = hit_div | hit_fbd | hit_trm | hit_aux | hit_ref | hit_prn |
                          hit_osc | hit_psv;
   wire [2:0]   wr_ratio = pwdata[`CKC_F_RATIO_HI:`CKC_F_RATIO_LO];
   wire         wr_slow  = pwdata[`CKC_B_SLOW_EN];
   // enable test uses the ratio that will hold after this write
   wire [2:0]   next_ratio = cpu_slow_enable ? slow_ratio : wr_ratio;              // [RULE2]
   wire         next_slow_req = wr_slow & (next_ratio != `CKC_RATIO_ZERO);         // [RULE1]
   wire         restore_hit = interrupt_restore_speed & irq_s2;                    // [RULE3]

   wire [15:0]  rd_div = {interrupt_restore_speed, slow_ratio, cpu_slow_enable, 6'h00,
                          pll_input_divider};
   wire [15:0]  rd_fbd = {7'h00, pll_feedback_value};                              // [RULE5]
   wire [15:0]  rd_trm = {10'h000, rc_trim_value};
   wire [15:0]  rd_aux = {aux_pll_on, lock_s2, 6'h00, aux_source_select,           // [RULE14]
                          aux_pll_internal_rc_select, 6'h00};
   wire [15:0]  rd_ref = {ref_clock_output_on, 3'h0, ref_clock_divider, 8'h00};
   wire [15:0]  rd_prn = {1'h0, pseudorandom_value};                               // [RULE9]
   wire [15:0]  rd_osc = {5'h00, new_oscillator_select, clock_locked, 7'h00};
   wire [15:0]  rd_psv = {14'h0000, power_state};
   wire [15:0]  rd_mux = hit_div ? rd_div : hit_fbd ? rd_fbd : hit_trm ? rd_trm :
                         hit_aux ? rd_aux : hit_ref ? rd_ref : hit_prn ? rd_prn :
                         hit_osc ? rd_osc : rd_psv;

   // ----------------------------------------------------------------
   // derived settings
   // ----------------------------------------------------------------
   function automatic logic [7:0] ckc_pow2(input logic [2:0] n);
      ckc_pow2 = 8'h01 << n;
   endfunction : ckc_pow2

   wire [7:0]   next_cpu_div = cpu_slow_enable ? ckc_pow2(slow_ratio) : 8'h01;     // [RULE12]
   wire [5:0]   next_pre     = {1'b0, pll_input_divider} + `CKC_PRE_OFFSET;        // [RULE4]
   wire [9:0]   next_fb      = {1'b0, pll_feedback_value} + `CKC_FB_OFFSET;
   wire         next_use_rc  = aux_pll_internal_rc_select | aux_source_select == 1'b0
                               ? aux_pll_internal_rc_select | ~aux_source_select
                               : 1'b0;                                             // [RULE7]
   wire [15:0]  next_ref_div = (ref_clock_divider == 4'h0) ? 16'h0000
                               : (16'h0001 << ref_clock_divider);                  // [RULE15]
   wire         next_pseudorandom_shift_value_fb = pseudorandom_value[14] ^ pseudorandom_value[13];
   wire         psave_go     = wr_go & hit_psv;

   // ----------------------------------------------------------------
   // apb answer
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (rd_go) begin
            prdata <= {16'h0000, mapped ? rd_mux : 16'h0000};
         end
      end
   end

   // ----------------------------------------------------------------
   // synchronisers
   // ----------------------------------------------------------------
   // async pins pass two flops before any logic reads them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {lock_s1, lock_s2, irq_s1, irq_s2, wake_s1, wake_s2} <= 6'h00;
      end else if (clk_en) begin
         lock_s1 <= aux_pll_lock_pin;
         lock_s2 <= lock_s1;
         irq_s1  <= irq_event;
         irq_s2  <= irq_s1;
         wake_s1 <= wake_event;
         wake_s2 <= wake_s1;
      end
   end

   // ----------------------------------------------------------------
   // speed control register
   // ----------------------------------------------------------------
   // a write lands only in the access cycle that is answered
   wire do_wr = wr_go & pready;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_restore_speed <= 1'b0;
         slow_ratio              <= `CKC_RST_RATIO;
         cpu_slow_enable         <= 1'b0;
         pll_input_divider       <= 5'h00;
      end else if (clk_en) begin
         if (do_wr & hit_div) begin
            interrupt_restore_speed <= pwdata[`CKC_B_RESTORE];
            slow_ratio              <= next_ratio;                                 // [RULE2]
            pll_input_divider       <= pwdata[`CKC_F_PRE_HI:`CKC_F_PRE_LO];
         end
         // interrupt clear wins over a software set in the same cycle
         if (restore_hit) begin
            cpu_slow_enable <= 1'b0;                                               // [RULE3]
         end else if (do_wr & hit_div) begin
            cpu_slow_enable <= next_slow_req;                                      // [RULE1]
         end
      end
   end

   // ----------------------------------------------------------------
   // other configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_feedback_value         <= `CKC_RST_FB;
         rc_trim_value              <= 6'h00;
         aux_pll_on                 <= 1'b0;
         aux_source_select          <= 1'b0;
         aux_pll_internal_rc_select <= `CKC_RST_AUX_RC;
         ref_clock_output_on        <= 1'b0;
         ref_clock_divider          <= 4'h0;
      end else if (clk_en) begin
         if (do_wr & hit_fbd) begin
            pll_feedback_value <= pwdata[`CKC_F_FB_HI:0];                          // [RULE5]
         end
         if (do_wr & hit_trm) begin
            rc_trim_value <= pwdata[`CKC_F_TRIM_HI:0];                             // [RULE6]
         end
         if (do_wr & hit_aux) begin
            aux_pll_on                 <= pwdata[`CKC_B_AUX_ON];
            aux_source_select          <= pwdata[`CKC_B_AUX_SRC];
            aux_pll_internal_rc_select <= pwdata[`CKC_B_AUX_RCSEL];
         end
         if (do_wr & hit_ref) begin
            ref_clock_output_on <= pwdata[`CKC_B_REF_ON];
            // divider taken only while output is off; software turns it off first
            if (!ref_clock_output_on) begin
               ref_clock_divider <= pwdata[`CKC_F_REFDIV_HI:`CKC_F_REFDIV_LO];    // [RULE8]
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // oscillator selection
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         new_oscillator_select <= 3'h0;
         clock_locked          <= 1'b0;
      end else if (clk_en) begin
         if (do_wr & hit_osc) begin
            if (!clock_locked) begin
               new_oscillator_select <= pwdata[`CKC_F_NEW_OSCILLATOR_SELECT_HI:`CKC_F_NEW_OSCILLATOR_SELECT_LO];    // [RULE10]
            end
            // lock is sticky until reset
            clock_locked <= clock_locked | pwdata[`CKC_B_CLK_LOCK];
         end
      end
   end

   // ----------------------------------------------------------------
   // pseudorandom register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pseudorandom_value <= 15'h0000;
      end else if (clk_en) begin
         if (do_wr & hit_prn) begin
            pseudorandom_value <= pwdata[`CKC_F_PRN_HI:0];                         // [RULE9]
         end else if (rd_go & hit_prn) begin
            pseudorandom_value <= {pseudorandom_value[13:0], ~next_pseudorandom_shift_value_fb};
         end
      end
   end

   // ----------------------------------------------------------------
   // power save state
   // ----------------------------------------------------------------
   ckc_power_t next_power;

   always_comb begin
      next_power = power_state;
      unique case (power_state)
         CKC_RUN: begin
            if (psave_go) begin
               next_power = pwdata[`CKC_B_PSAV_MODE] ? CKC_IN_IDLE : CKC_IN_SLEEP; // [RULE11]
            end
         end
         // any synchronised wake or interrupt ends sleep and idle alike
         CKC_IN_SLEEP, CKC_IN_IDLE: begin
            if (wake_s2 | irq_s2) begin
               next_power = CKC_RUN;
            end
         end
         default: next_power = CKC_RUN;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_state <= CKC_RUN;
      end else if (clk_en) begin
         power_state <= next_power;
      end
   end

   // ----------------------------------------------------------------
   // registered settings outputs
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_ratio_div       <= 8'h01;
         pll_in_div          <= `CKC_PRE_OFFSET;
         pll_fb_mult         <= {1'b0, `CKC_RST_FB} + `CKC_FB_OFFSET;
         aux_use_internal_rc <= `CKC_RST_AUX_RC;
         aux_pll_mult        <= 5'(`CKC_AUX_MULT);
         ref_div_ratio_log2  <= 16'h0000;
      end else if (clk_en) begin
         cpu_ratio_div       <= next_cpu_div;
         pll_in_div          <= next_pre;
         pll_fb_mult         <= next_fb;
         aux_use_internal_rc <= next_use_rc;
         aux_pll_mult        <= 5'(`CKC_AUX_MULT);                                 // [RULE13]
         ref_div_ratio_log2  <= next_ref_div;
      end
   end

endmodule : ckc_clock_ctrl

// File: testbench/ckc_clock_ctrl_sva.sv
`timescale 1ns/10ps
// ----------------------------------------
// port checker for the clock control block
// ----------------------------------------
module ckc_clock_ctrl_sva (
   // clock, reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // clock settings
   input wire logic [7:0]  cpu_ratio_div,
   input wire logic [5:0]  pll_in_div,
   input wire logic [9:0]  pll_fb_mult,
   input wire logic [4:0]  aux_pll_mult,
   input wire logic        ref_clock_output_on,
   input wire logic [15:0] ref_div_ratio_log2
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence apb_setup_s;
      psel && !penable;
   endsequence
   sequence apb_access_s;
      psel && penable && pready;
   endsequence
   apb_answer_a: assert property (apb_setup_s |=> apb_access_s)
      else $error("no ready in access cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error without ready or with data");
   ratio_onehot_a: assert property ($onehot(cpu_ratio_div))
      else $error("cpu ratio not a power of two");
   ratio_hold_a: assert property (cpu_ratio_div != 8'h01
      && $past(cpu_ratio_div) != 8'h01 |-> $stable(cpu_ratio_div))
      else $error("ratio changed while slowed");
   prediv_range_a: assert property (pll_in_div inside {[6'h02:6'h21]})
      else $error("input divider out of range");
   fb_range_a: assert property (pll_fb_mult inside {[10'h002:10'h201]})
      else $error("feedback value out of range");
   aux_mult_a: assert property (aux_pll_mult == 5'h10)
      else $error("aux multiplier not sixteen");
   ref_hold_a: assert property (ref_clock_output_on && $past(ref_clock_output_on)
      && $past(ref_clock_output_on, 2) |-> $stable(ref_div_ratio_log2))
      else $error("ref divider changed while on");
   ref_form_a: assert property ($onehot0(ref_div_ratio_log2) && !ref_div_ratio_log2[0])
      else $error("ref divider form wrong");
endmodule : ckc_clock_ctrl_sva

bind ckc_clock_ctrl ckc_clock_ctrl_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cpu_ratio_div(cpu_ratio_div), .pll_in_div(pll_in_div), .pll_fb_mult(pll_fb_mult),
   .aux_pll_mult(aux_pll_mult), .ref_clock_output_on(ref_clock_output_on),
   .ref_div_ratio_log2(ref_div_ratio_log2));

// File: testbench/testbench.sv
`timescale 1ns/10ps
`include "ckc_regs.svh"
module testbench;
   import ckc_pkg::*;
   logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
   logic        irq_event, aux_pll_lock_pin, wake_event, aux_pll_on, aux_use_internal_rc;
   logic        ref_clock_output_on, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [7:0]  cpu_ratio_div;
   logic [5:0]  pll_in_div, rc_trim_value;
   logic [9:0]  pll_fb_mult;
   logic [4:0]  aux_pll_mult;
   logic [15:0] ref_div_ratio_log2;
   logic [2:0]  new_oscillator_select;
   ckc_power_t  power_state;
   int          errors, cmp_count;
   ckc_clock_ctrl uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq_event(irq_event),
      .aux_pll_lock_pin(aux_pll_lock_pin), .wake_event(wake_event),
      .cpu_ratio_div(cpu_ratio_div), .pll_in_div(pll_in_div), .pll_fb_mult(pll_fb_mult),
      .rc_trim_value(rc_trim_value), .aux_pll_on(aux_pll_on),
      .aux_use_internal_rc(aux_use_internal_rc), .aux_pll_mult(aux_pll_mult),
      .ref_clock_output_on(ref_clock_output_on), .ref_div_ratio_log2(ref_div_ratio_log2),
      .new_oscillator_select(new_oscillator_select), .power_state(power_state));
   always #4 pclk = ~pclk;
   // ----------------------------------------
   // bus and compare tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees ready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      // settings outputs are registered one cycle after the register
      hold(2);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rdat, exp);
   endtask : rd
   task automatic hold(input int n);
      repeat (n) @(posedge pclk);
   endtask : hold
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_values;
      logic [11:0] ofs [8] = '{`CKC_OFS_CLKDIV, `CKC_OFS_FBD, `CKC_OFS_TRIM, `CKC_OFS_AUX,
                               `CKC_OFS_REFO, `CKC_OFS_PRN, `CKC_OFS_OSC, `CKC_OFS_PSAV};
      logic [31:0] rst [8] = '{32'h3000, 32'h30, 32'h0, 32'h40, 32'h0, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 8; i++) rd(ofs[i], rst[i]);
      check(32'(pll_in_div), 32'h2);
   endtask : t_reset_values
   task automatic t_slow;
      wr(`CKC_OFS_CLKDIV, 32'h0800);
      rd(`CKC_OFS_CLKDIV, 32'h0000);
      wr(`CKC_OFS_CLKDIV, 32'h7800);
      check(32'(cpu_ratio_div), 32'h80);
      wr(`CKC_OFS_CLKDIV, 32'h2800);
      rd(`CKC_OFS_CLKDIV, 32'h7800);
      wr(`CKC_OFS_CLKDIV, 32'hA800);
      irq_event <= 1'b1;
      hold(4);
      irq_event <= 1'b0;
      hold(4);
      rd(`CKC_OFS_CLKDIV, 32'hF000);
      check(32'(cpu_ratio_div), 32'h1);
   endtask : t_slow
   task automatic t_pll;
      wr(`CKC_OFS_CLKDIV, 32'h001F);
      check(32'(pll_in_div), 32'd33);
      wr(`CKC_OFS_FBD, 32'hFFFF);
      rd(`CKC_OFS_FBD, 32'h01FF);
      check(32'(pll_fb_mult), 32'h201);
      wr(`CKC_OFS_TRIM, 32'hFFFF);
      rd(`CKC_OFS_TRIM, 32'h003F);
      check(32'(rc_trim_value), 32'h3F);
   endtask : t_pll
   task automatic t_aux;
      aux_pll_lock_pin <= 1'b1;
      wr(`CKC_OFS_AUX, 32'hFFFF);
      rd(`CKC_OFS_AUX, 32'hC0C0);
      check(32'({aux_pll_on, aux_use_internal_rc}), 32'h3);
      check(32'(aux_pll_mult), 32'h10);
      aux_pll_lock_pin <= 1'b0;
      wr(`CKC_OFS_AUX, 32'h4080);
      rd(`CKC_OFS_AUX, 32'h0080);
      check(32'(aux_use_internal_rc), 32'h0);
      wr(`CKC_OFS_AUX, 32'h0000);
      check(32'(aux_use_internal_rc), 32'h1);
   endtask : t_aux
   task automatic t_ref;
      wr(`CKC_OFS_REFO, 32'h0E00);
      wr(`CKC_OFS_REFO, 32'h8E00);
      wr(`CKC_OFS_REFO, 32'h8100);
      rd(`CKC_OFS_REFO, 32'h8E00);
      check(32'(ref_clock_output_on), 32'h1);
      check(32'(ref_div_ratio_log2), 32'h4000);
      wr(`CKC_OFS_REFO, 32'h0E00);
      wr(`CKC_OFS_REFO, 32'h0000);
      check(32'(ref_div_ratio_log2), 32'h0);
      wr(`CKC_OFS_REFO, 32'h0F00);
      check(32'(ref_div_ratio_log2), 32'h8000);
   endtask : t_ref
   task automatic t_misc;
      wr(`CKC_OFS_PRN, 32'hFFFF);
      rd(`CKC_OFS_PRN, 32'h7FFF);
      for (int m = 0; m < 2; m++) begin
         wr(`CKC_OFS_PSAV, 32'(m));
         rd(`CKC_OFS_PSAV, 32'(m + 1));
         wake_event <= 1'b1;
         hold(4);
         wake_event <= 1'b0;
         hold(4);
         check(32'(power_state), 32'(CKC_RUN));
      end
      rd(12'h020, 32'h0);
      check(32'(rerr), 32'h1);
      wr(`CKC_OFS_OSC, 32'h0500);
      check(32'(new_oscillator_select), 32'h5);
      wr(`CKC_OFS_OSC, 32'h0080);
      wr(`CKC_OFS_OSC, 32'h0780);
      rd(`CKC_OFS_OSC, 32'h0080);
   endtask : t_misc
   task automatic t_freeze;
      wr(`CKC_OFS_PSAV, 32'h0);
      clk_en <= 1'b0;
      wake_event <= 1'b1;
      hold(6);
      wake_event <= 1'b0;
      check(32'(power_state), 32'(CKC_IN_SLEEP));
      clk_en <= 1'b1;
      wake_event <= 1'b1;
      hold(4);
      wake_event <= 1'b0;
      hold(4);
      check(32'(power_state), 32'(CKC_RUN));
   endtask : t_freeze
   initial begin
      {pclk, presetn, psel, penable, pwrite, irq_event, aux_pll_lock_pin, wake_event} = '0;
      clk_en = 1'b1;
      paddr = '0;
      pwdata = '0;
      errors = 0;
      cmp_count = 0;
      hold(16);
      presetn <= 1'b1;
      t_reset_values();
      t_slow();
      t_pll();
      t_aux();
      t_ref();
      t_misc();
      t_freeze();
      tally_and_finish();
   end
   initial begin
      #100000;
      errors++;
      tally_and_finish();
   end
endmodule : testbench
